// [common/ipw_pkg.sv]
/*
 package of the interrupt and power-down wake block: register offsets, field positions,
 reset values, source numbering, polling order and vector constants.
 assumes nothing of its surroundings.
*/
`default_nettype none
package ipw_pkg;
   localparam int         NUM_SRC        = 15;
   localparam int         NUM_EXT        = 6;
   // register byte offsets on the avalon slave
   localparam logic [7:0] OFF_EN0        = 8'h00;
   localparam logic [7:0] OFF_EN1        = 8'h04;
   localparam logic [7:0] OFF_PRIO0      = 8'h08;
   localparam logic [7:0] OFF_PRIO1      = 8'h0C;
   localparam logic [7:0] OFF_TIMER_CTL  = 8'h10;
   localparam logic [7:0] OFF_EDGE_CFG   = 8'h14;
   localparam logic [7:0] OFF_POWER_CTL  = 8'h18;
   localparam logic [7:0] OFF_DISP_CFG   = 8'h1C;
   localparam logic [7:0] OFF_CAPTION    = 8'h20;
   localparam logic [7:0] OFF_STATUS     = 8'h24;
   localparam logic [7:0] OFF_RETURN     = 8'h28;
   // field positions
   localparam int         GATE_BIT       = 7;
   localparam int         SENSE0_BIT     = 0;
   localparam int         SENSE1_BIT     = 2;
   localparam int         DOZE_BIT       = 0;
   localparam int         SLEEP_BIT      = 1;
   localparam int         BUSY_MODE_BIT  = 0;
   localparam int         CAPTION_W      = 5;
   // reset values
   localparam logic [7:0] RST_BYTE       = 8'h00;
   // source numbers
   localparam int         SRC_EXT0       = 0;
   localparam int         SRC_TMR0       = 1;
   localparam int         SRC_EXT1       = 2;
   localparam int         SRC_TMR1       = 3;
   localparam int         SRC_CAPTION    = 4;
   localparam int         SRC_TWI        = 5;
   localparam int         SRC_BUSY       = 6;
   localparam int         SRC_TMR2       = 7;
   localparam int         SRC_UART_ANY   = 8;
   localparam int         SRC_UART_TX    = 9;
   localparam int         SRC_UART_RX    = 10;
   localparam int         SRC_EXT2       = 11;
   // fixed polling order, entry 0 polled first, four bits per entry
   localparam logic [59:0] POLL_ORDER    = {4'hE, 4'h9, 4'h4, 4'hD, 4'h8, 4'h3, 4'hC, 4'h7,
                                            4'h2, 4'hB, 4'h6, 4'h1, 4'hA, 4'h5, 4'h0};
   localparam logic [15:0] VEC_BASE      = 16'h0003;
   localparam int          VEC_SHIFT     = 3;
   localparam logic [15:0] RESTART_ADDR  = 16'h0000;
   // external line sense modes
   typedef enum logic [1:0] {
      IPW_LEVEL_LOW = 2'b00,
      IPW_RISE      = 2'b01,
      IPW_FALL      = 2'b10,
      IPW_BOTH      = 2'b11
   } ipw_sense_t;
endpackage
`default_nettype wire

// [hw/ipw_ext_sense.sv]
/*
 one external interrupt line: two-flop synchroniser, level and edge detection.
 assumes the pin is free running with respect to clk; mode may change at any time.
*/
`timescale 1ns/1ps
`default_nettype none
module ipw_ext_sense
   import ipw_pkg::*;
(
   input  wire logic       clk,
   input  wire logic       reset,
   input  wire logic       pin,
   input  wire logic [1:0] mode,
   output logic            level_req,
   output logic            edge_evt
);
   logic meta_reg;
   logic sync_reg;
   logic prev_reg;

   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         meta_reg <= 1'b1;
         sync_reg <= 1'b1;
         prev_reg <= 1'b1;
      end
      else
      begin
         meta_reg <= pin;
         sync_reg <= meta_reg;
         prev_reg <= sync_reg;
      end
   end

   always_comb
   begin
      level_req = (mode == IPW_LEVEL_LOW) && !sync_reg;
      unique case (mode)
         IPW_RISE:  edge_evt = sync_reg && !prev_reg;
         IPW_FALL:  edge_evt = !sync_reg && prev_reg;
         IPW_BOTH:  edge_evt = sync_reg != prev_reg;
         default:   edge_evt = 1'b0;
      endcase
   end
endmodule
`default_nettype wire

// [hw/ipw_top.sv]
/*
 interrupt controller with power-down and idle wake, registers on an avalon-mm slave.
 assumes the cpu holds call_ack for one cycle when it takes the hardware call and pulses
 cpu_reti at each return; peripheral event inputs are one-cycle pulses on clk.
*/
// Operation
// - fifteen sources, each with its own enable bit
// - each source gets low or high priority; enables and priorities in four registers
// - clearing the global gate bit 7 of first enable register blocks all sources
// - low service preempted only by high; high service never preempted
// - high level wins; equal levels resolved by fixed polling order
// - source n vectors to 0003h plus 8n; fixed polling order 0,5,10,1,...
// - a granted request issues a hardware call to its vector
// - caption-ready fires at end of the selected slice line in caption mode
// - display-busy mode chosen by busy_mode_sel configuration bit
// - text mode: each active line at hblank; vertical mode: once per field
// - four extra lines: 00 level low, 01 rising, 10 falling, 11 both
// - legacy line sense bits select low level or edge sensing
// - legacy line zero edges falling only; line one both edges
// - peripheral sources: two-wire serial, uart receive, transmit, receive-or-transmit
// - sleep_bit enters power-down; clock stops, register state kept, aux memory lost
// - port pins keep driving their register values during power-down
// - level-sensitive external request wakes from power-down, then resumes after sleep
// - analog key comparator threshold also wakes from power-down
// - hardware reset initialises registers and display memory, restarts at 0000
// - any enabled request in idle clears doze_flag before service
`timescale 1ns/1ps
`default_nettype none
module ipw_top
   import ipw_pkg::*;
#(
   parameter int SRC_N = NUM_SRC
)
(
   input  wire logic                 clk,
   input  wire logic                 reset,
   // avalon-mm slave
   input  wire logic [7:0]           address,
   input  wire logic                 read,
   input  wire logic                 write,
   input  wire logic [31:0]          writedata,
   input  wire logic [3:0]           byteenable,
   output logic      [31:0]          readdata,
   output logic                      waitrequest,
   // external interrupt pins: zero, one, then the four extra lines
   input  wire logic                 ext_line_zero,
   input  wire logic                 ext_line_one,
   input  wire logic [3:0]           ext_line_extra,
   // peripheral event pulses
   input  wire logic                 timer0_evt,
   input  wire logic                 timer1_evt,
   input  wire logic                 timer2_evt,
   input  wire logic                 twi_evt,
   input  wire logic                 uart_rx_evt,
   input  wire logic                 uart_tx_evt,
   // display and caption timing
   input  wire logic                 caption_mode,
   input  wire logic                 slice_line_end,
   input  wire logic [CAPTION_W-1:0] line_number,
   input  wire logic                 hblank_enter,
   input  wire logic                 line_active,
   input  wire logic                 vblank_enter,
   input  wire logic                 analog_key_comparator,
   // cpu call interface
   input  wire logic                 call_ack,
   input  wire logic                 cpu_reti,
   output logic                      call_req,
   output logic      [15:0]          call_vector,
   // power state
   output logic                      power_down,
   output logic                      idle_mode,
   output logic                      aux_mem_lost,
   output logic                      restart_req,
   output logic      [15:0]          restart_addr
);
   typedef enum logic [1:0] {
      IPW_ST_IDLE = 2'b01,
      IPW_ST_CALL = 2'b10
   } ipw_state_t;

   logic [7:0]           en0_reg;
   logic [7:0]           en1_reg;
   logic [7:0]           prio0_reg;
   logic [7:0]           prio1_reg;
   logic [7:0]           timer_ctl_reg;
   logic [7:0]           edge_cfg_reg;
   logic                 busy_mode_reg;
   logic [CAPTION_W-1:0] caption_sel_reg;
   logic                 doze_reg;
   logic                 pd_reg;
   logic                 aux_lost_reg;
   logic                 restart_reg;
   logic [SRC_N-1:0]     flag_reg;
   logic                 act_hi_reg;
   logic                 act_lo_reg;
   ipw_state_t           state_reg;
   logic [3:0]           win_src_reg;
   logic                 win_hi_reg;
   logic [15:0]          vector_reg;
   logic [31:0]          rdata_reg;
   logic                 wait_reg;

   logic [NUM_EXT-1:0]   ext_pin;
   logic [1:0]           ext_mode [NUM_EXT];
   logic [NUM_EXT-1:0]   ext_level;
   logic [NUM_EXT-1:0]   ext_edge;
   logic [SRC_N-1:0]     evt_set;
   logic [SRC_N-1:0]     level_src;
   logic [SRC_N-1:0]     pending;
   logic [SRC_N-1:0]     enable;
   logic [SRC_N-1:0]     prio;
   logic [SRC_N-1:0]     cand;
   logic [SRC_N-1:0]     flag_clr;
   logic                 caption_evt;
   logic                 busy_evt;
   logic                 win_found;
   logic                 win_hi;
   logic [3:0]           win_src;
   logic                 acc_wr;
   logic                 lane0;
   logic                 wake;

   assign ext_pin = {ext_line_extra, ext_line_one, ext_line_zero};
   assign acc_wr  = write && !wait_reg;
   assign lane0   = byteenable[0];

   // sense mode of each line
   always_comb
   begin
      ext_mode[0] = timer_ctl_reg[SENSE0_BIT] ? IPW_FALL : IPW_LEVEL_LOW;
      ext_mode[1] = timer_ctl_reg[SENSE1_BIT] ? IPW_BOTH : IPW_LEVEL_LOW;
      for (int k = 2; k < NUM_EXT; k++)
      begin
         ext_mode[k] = edge_cfg_reg[2*(k-2) +: 2];
      end
   end

   genvar g;
   generate
      for (g = 0; g < NUM_EXT; g++)
      begin : g_ext
         ipw_ext_sense u_sense (
            .clk       (clk),
            .reset     (reset),
            .pin       (ext_pin[g]),
            .mode      (ext_mode[g]),
            .level_req (ext_level[g]),
            .edge_evt  (ext_edge[g])
         );
      end
   endgenerate

   assign caption_evt = caption_mode && slice_line_end && (line_number == caption_sel_reg);
   assign busy_evt    = busy_mode_reg ? (hblank_enter && line_active) : vblank_enter;

   // source map: events latch in flags, level-mode lines feed straight through
   always_comb
   begin
      evt_set                  = '0;
      level_src                = '0;
      evt_set[SRC_EXT0]        = ext_edge[0];
      evt_set[SRC_EXT1]        = ext_edge[1];
      level_src[SRC_EXT0]      = ext_level[0];
      level_src[SRC_EXT1]      = ext_level[1];
      for (int k = 2; k < NUM_EXT; k++)
      begin
         evt_set[SRC_EXT2+k-2]   = ext_edge[k];
         level_src[SRC_EXT2+k-2] = ext_level[k];
      end
      evt_set[SRC_TMR0]        = timer0_evt;
      evt_set[SRC_TMR1]        = timer1_evt;
      evt_set[SRC_TMR2]        = timer2_evt;
      evt_set[SRC_CAPTION]     = caption_evt;
      evt_set[SRC_BUSY]        = busy_evt;
      evt_set[SRC_TWI]         = twi_evt;
      evt_set[SRC_UART_RX]     = uart_rx_evt;
      evt_set[SRC_UART_TX]     = uart_tx_evt;
      evt_set[SRC_UART_ANY]    = uart_rx_evt || uart_tx_evt;
   end

   assign pending = flag_reg | level_src;
   assign enable  = {en1_reg, en0_reg[6:0]};
   assign prio    = {prio1_reg, prio0_reg[6:0]};
   assign cand    = en0_reg[GATE_BIT] ? (pending & enable) : '0;

   // arbitration: level first, then polling order within it
   always_comb
   begin
      logic [3:0] idx;
      idx       = 4'h0;
      win_found = 1'b0;
      win_hi    = 1'b0;
      win_src   = 4'h0;
      if (!act_hi_reg && |(cand & prio))
      begin
         win_hi = 1'b1;
      end
      for (int k = 0; k < SRC_N; k++)
      begin
         idx = POLL_ORDER[4*k +: 4];
         if (!win_found && cand[idx] && (prio[idx] == win_hi)
             && (win_hi || (!act_hi_reg && !act_lo_reg)))
         begin
            win_found = 1'b1;
            win_src   = idx;
         end
      end
   end

   always_comb
   begin
      flag_clr = '0;
      if (state_reg == IPW_ST_CALL && call_ack)
      begin
         flag_clr[win_src_reg] = 1'b1;
      end
   end

   // edge-latched flags; a new event in the clearing cycle is kept
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         flag_reg <= '0;
      end
      else
      begin
         flag_reg <= (flag_reg & ~flag_clr) | evt_set;
      end
   end

   // hardware call sequencer; no new call leaves idle while pd_reg is set, a pending call still completes
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         state_reg   <= IPW_ST_IDLE;
         win_src_reg <= 4'h0;
         win_hi_reg  <= 1'b0;
         vector_reg  <= VEC_BASE;
      end
      else
      begin
         unique case (state_reg)
            IPW_ST_IDLE:
            begin
               if (win_found && !pd_reg)
               begin
                  state_reg   <= IPW_ST_CALL;
                  win_src_reg <= win_src;
                  win_hi_reg  <= win_hi;
                  vector_reg  <= VEC_BASE + (16'(win_src) << VEC_SHIFT);
               end
            end
            IPW_ST_CALL:
            begin
               if (call_ack)
               begin
                  state_reg <= IPW_ST_IDLE;
               end
            end
            default:
            begin
               state_reg <= IPW_ST_IDLE;
            end
         endcase
      end
   end

   // service level tracking: taken call marks a level, return releases the highest
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         act_hi_reg <= 1'b0;
         act_lo_reg <= 1'b0;
      end
      else if (state_reg == IPW_ST_CALL && call_ack)
      begin
         if (win_hi_reg)
         begin
            act_hi_reg <= 1'b1;
         end
         else
         begin
            act_lo_reg <= 1'b1;
         end
      end
      else if (cpu_reti)
      begin
         if (act_hi_reg)
         begin
            act_hi_reg <= 1'b0;
         end
         else
         begin
            act_lo_reg <= 1'b0;
         end
      end
   end

   // configuration registers
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         en0_reg         <= RST_BYTE;
         en1_reg         <= RST_BYTE;
         prio0_reg       <= RST_BYTE;
         prio1_reg       <= RST_BYTE;
         timer_ctl_reg   <= RST_BYTE;
         edge_cfg_reg    <= RST_BYTE;
         busy_mode_reg   <= 1'b0;
         caption_sel_reg <= '0;
      end
      else if (acc_wr && lane0)
      begin
         unique case (address)
            OFF_EN0:       en0_reg <= writedata[7:0];
            OFF_EN1:       en1_reg <= writedata[7:0];
            OFF_PRIO0:     prio0_reg <= writedata[7:0];
            OFF_PRIO1:     prio1_reg <= writedata[7:0];
            OFF_TIMER_CTL: timer_ctl_reg <= writedata[7:0];
            OFF_EDGE_CFG:  edge_cfg_reg <= writedata[7:0];
            OFF_DISP_CFG:  busy_mode_reg <= writedata[BUSY_MODE_BIT];
            OFF_CAPTION:   caption_sel_reg <= writedata[CAPTION_W-1:0];
            default:
            begin
            end
         endcase
      end
   end

   // wake: enabled level request on an external line, or the key comparator
   assign wake = |(cand & level_src) || analog_key_comparator;

   // power state; hardware idle exit wins over a same-cycle software set
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         doze_reg     <= 1'b0;
         pd_reg       <= 1'b0;
         aux_lost_reg <= 1'b0;
         restart_reg  <= 1'b1;
      end
      else
      begin
         restart_reg  <= 1'b0;
         aux_lost_reg <= 1'b0;
         if (|cand)
         begin
            doze_reg <= 1'b0;
         end
         else if (acc_wr && lane0 && address == OFF_POWER_CTL)
         begin
            doze_reg <= writedata[DOZE_BIT];
         end
         if (acc_wr && lane0 && address == OFF_POWER_CTL && writedata[SLEEP_BIT] && !pd_reg)
         begin
            pd_reg       <= 1'b1;
            aux_lost_reg <= 1'b1;
         end
         else if (pd_reg && wake)
         begin
            pd_reg <= 1'b0;
         end
      end
   end

   // avalon slave: one wait state, access completes when waitrequest is low
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         wait_reg  <= 1'b1;
         rdata_reg <= '0;
      end
      else
      begin
         wait_reg <= !((read || write) && wait_reg);
         if (read && wait_reg)
         begin
            unique case (address)
               OFF_EN0:       rdata_reg <= {24'h00_0000, en0_reg};
               OFF_EN1:       rdata_reg <= {24'h00_0000, en1_reg};
               OFF_PRIO0:     rdata_reg <= {24'h00_0000, prio0_reg};
               OFF_PRIO1:     rdata_reg <= {24'h00_0000, prio1_reg};
               OFF_TIMER_CTL: rdata_reg <= {24'h00_0000, timer_ctl_reg};
               OFF_EDGE_CFG:  rdata_reg <= {24'h00_0000, edge_cfg_reg};
               OFF_POWER_CTL: rdata_reg <= {30'h0000_0000, pd_reg, doze_reg};
               OFF_DISP_CFG:  rdata_reg <= {31'h0000_0000, busy_mode_reg};
               OFF_CAPTION:   rdata_reg <= {{(32-CAPTION_W){1'b0}}, caption_sel_reg};
               OFF_STATUS:    rdata_reg <= {13'h0000, state_reg == IPW_ST_CALL, act_hi_reg,
                                            act_lo_reg, 1'b0, pending};
               default:       rdata_reg <= '0;
            endcase
         end
      end
   end

   assign readdata     = rdata_reg;
   assign waitrequest  = wait_reg;
   assign call_req     = state_reg == IPW_ST_CALL;
   assign call_vector  = vector_reg;
   assign power_down   = pd_reg;
   assign idle_mode    = doze_reg;
   assign aux_mem_lost = aux_lost_reg;
   assign restart_req  = restart_reg;
   assign restart_addr = RESTART_ADDR;
endmodule
`default_nettype wire

// [bench/ipw_props.sv]
/*
 checker for ipw_top: bus wait state, hardware call handshake, power and restart outputs.
 assumes it is bound to ipw_top and sees only its ports.
*/
`timescale 1ns/1ps
`default_nettype none
module ipw_props
(
   input wire logic        clk,
   input wire logic        reset,
   input wire logic        read,
   input wire logic        write,
   input wire logic        waitrequest,
   input wire logic        call_req,
   input wire logic        call_ack,
   input wire logic [15:0] call_vector,
   input wire logic        power_down,
   input wire logic        aux_mem_lost,
   input wire logic        restart_req,
   input wire logic [15:0] restart_addr
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);
   sequence bus_req_s;
      (read || write) && waitrequest;
   endsequence
   sequence grant_s;
      call_req && call_ack;
   endsequence
   sequence release_s;
      restart_req ##1 !restart_req;
   endsequence
   wait_state_a: assert property (bus_req_s |=> !waitrequest)
      else $error("bus answer missed its wait state");
   wait_pulse_a: assert property (!waitrequest |=> waitrequest)
      else $error("waitrequest low for more than one cycle");
   call_hold_a: assert property (call_req && !call_ack |=> call_req && $stable(call_vector))
      else $error("call request dropped or vector moved before acknowledge");
   call_drop_a: assert property (grant_s |=> !call_req)
      else $error("call request stayed up after acknowledge");
   vec_form_a: assert property (call_req |-> call_vector[2:0] == 3'h3 && call_vector <= 16'h0073)
      else $error("call vector outside the vector table");
   pd_block_a: assert property ($rose(call_req) |-> !$past(power_down))
      else $error("call issued during power-down");
   aux_pulse_a: assert property ((aux_mem_lost |=> !aux_mem_lost) and ($rose(power_down) |-> aux_mem_lost))
      else $error("memory loss flag wrong");
   restart_seq_a: assert property ($fell(reset) |-> release_s)
      else $error("restart request not one cycle after reset");
   restart_addr_a: assert property (restart_addr == 16'h0000)
      else $error("restart address not zero");
endmodule
bind ipw_top ipw_props u_ipw_props (.clk(clk), .reset(reset), .read(read), .write(write),
   .waitrequest(waitrequest), .call_req(call_req), .call_ack(call_ack), .call_vector(call_vector),
   .power_down(power_down), .aux_mem_lost(aux_mem_lost), .restart_req(restart_req),
   .restart_addr(restart_addr));
`default_nettype wire

// [bench/ipw_cpu_model.sv]
/*
 cpu core stand-in: acknowledges each hardware call lat+1 cycles after the request and returns on command.
 assumes the call port of ipw_top on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none
module ipw_cpu_model
(
   input  wire logic        clk,
   input  wire logic        reset,
   input  wire logic        call_req,
   input  wire logic [15:0] call_vector,
   input  wire logic [1:0]  lat,
   input  wire logic        ret_cmd,
   output logic             call_ack,
   output logic             cpu_reti,
   output logic             taken,
   output logic      [15:0] taken_vec
);
   logic [1:0] wait_reg;
   always_ff @(posedge clk)
   begin
      if (reset || !call_req || call_ack)
         wait_reg <= 2'h0;
      else if (wait_reg != lat)
         wait_reg <= wait_reg + 2'h1;
   end
   always_ff @(posedge clk)
   begin
      call_ack  <= !reset && call_req && !call_ack && wait_reg == lat;
      taken     <= !reset && call_req && call_ack;
      taken_vec <= call_vector;
      cpu_reti  <= !reset && ret_cmd;
   end
endmodule
`default_nettype wire

// [bench/ipw_top_test.sv]
/*
 self-checking bench of ipw_top with the cpu model on the call port.
 assumes the avalon slave answers after one wait state.
*/
`timescale 1ns/1ps
`default_nettype none
module ipw_top_test
   import ipw_pkg::*;
;
   logic        clk = 0, reset = 1, read = 0, write = 0, ret_cmd = 0;
   logic        caption_mode = 0, line_active = 0, comp = 0, taken, call_req, call_ack, cpu_reti;
   logic        waitrequest, power_down, idle_mode, aux_mem_lost, restart_req;
   logic [7:0]  address = 0;
   logic [31:0] writedata = 0, readdata;
   logic [3:0]  byteenable = 4'hF;
   logic [5:0]  pins = 6'h3F;
   logic [8:0]  ev = 0;
   logic [4:0]  line_number = 0;
   logic [1:0]  lat = 0;
   logic [15:0] call_vector, taken_vec, restart_addr;
   logic [31:0] rd_q[$];
   logic [15:0] vq[$];
   int          fails = 0, num_checks = 0, ncall = 0, nexp = 0, seed = 44;
   ipw_top u_ipw_top (.clk(clk), .reset(reset), .address(address), .read(read), .write(write),
      .writedata(writedata), .byteenable(byteenable), .readdata(readdata), .waitrequest(waitrequest),
      .ext_line_zero(pins[0]), .ext_line_one(pins[1]), .ext_line_extra(pins[5:2]), .timer0_evt(ev[0]),
      .timer1_evt(ev[1]), .timer2_evt(ev[2]), .twi_evt(ev[3]), .uart_rx_evt(ev[4]), .uart_tx_evt(ev[5]),
      .caption_mode(caption_mode), .slice_line_end(ev[6]), .line_number(line_number),
      .hblank_enter(ev[7]), .line_active(line_active), .vblank_enter(ev[8]), .analog_key_comparator(comp),
      .call_ack(call_ack), .cpu_reti(cpu_reti), .call_req(call_req), .call_vector(call_vector),
      .power_down(power_down), .idle_mode(idle_mode), .aux_mem_lost(aux_mem_lost),
      .restart_req(restart_req), .restart_addr(restart_addr));
   ipw_cpu_model u_ipw_cpu_model (.clk(clk), .reset(reset), .call_req(call_req), .call_vector(call_vector),
      .lat(lat), .ret_cmd(ret_cmd), .call_ack(call_ack), .cpu_reti(cpu_reti), .taken(taken),
      .taken_vec(taken_vec));
   initial forever #5 clk = ~clk;
   task automatic results;
      if (fails == 0 && num_checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp)
      begin
         fails++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d, input logic [3:0] be);
      int n;
      read <= !w; write <= w; address <= a; writedata <= {24'h0, d}; byteenable <= be;
      n = 0;
      do
      begin
         @(posedge clk);
         n++;
      end while (waitrequest !== 1'b0 && n < 20);
      read <= 1'b0; write <= 1'b0;
      @(posedge clk);
      if (n == 20)
      begin
         fails++;
         results();
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      bus(1'b1, a, d, 4'hF);
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      rd_q.push_back({24'h0, e});
      bus(1'b0, a, 8'h00, 4'hF);
   endtask
   task automatic ret;
      ret_cmd <= 1'b1;
      @(posedge clk);
      ret_cmd <= 1'b0;
      @(posedge clk);
   endtask
   task automatic call(input logic [15:0] v, input bit r);
      int n;
      vq.push_back(v);
      nexp++;
      for (n = 0; n < 40 && ncall != nexp; n++) @(posedge clk);
      if (ncall != nexp)
      begin
         fails++;
         results();
      end
      if (r) ret();
   endtask
   task automatic quiet;
      repeat (10) @(posedge clk);
   endtask
   task automatic pulse(input logic [8:0] m);
      ev <= m;
      @(posedge clk);
      ev <= 9'h000;
   endtask
   always @(posedge clk)
   begin
      if (read && waitrequest === 1'b0)
         check("readdata", readdata, rd_q.size() ? rd_q.pop_front() : 32'hFFFF_FFFF);
      if (taken === 1'b1)
      begin
         ncall++;
         check("call_vector", {16'h0, taken_vec}, vq.size() ? {16'h0, vq.pop_front()} : 32'hFFFF_FFFF);
      end
   end
   initial
   begin
      int i, n, k;
      logic [5:0]  m;
      logic [14:0] s;
      repeat (20) @(posedge clk);
      reset <= 1'b0;
      @(posedge clk);
      for (i = 0; i <= 11; i++) rd(8'(4 * i), RST_BYTE);
      wr(OFF_CAPTION, 8'h3F);
      bus(1'b1, OFF_CAPTION, 8'h00, 4'h0);
      wr(OFF_STATUS, 8'hFF);
      wr(8'h2C, 8'hFF);
      rd(OFF_CAPTION, 8'h1F);
      rd(OFF_STATUS, 8'h00);
      rd(8'h2C, 8'h00);
      wr(OFF_EN1, 8'hFF);
      for (int j = 0; j < 2; j++)
      begin
         wr(OFF_EN0, j ? 8'hFD : 8'h7F);
         pulse(9'h001);
         quiet();
         wr(OFF_EN0, 8'hFF);
         call(16'h000B, 1);
      end
      for (k = 0; k < 6; k++)
      begin
         m = 6'($random(seed));
         if (m == 6'h00) m = 6'h01;
         s = 15'h0000;
         s[1] = m[0]; s[3] = m[1]; s[7] = m[2]; s[5] = m[3]; s[10] = m[4]; s[9] = m[5];
         s[8] = m[4] | m[5];
         lat <= 2'($random(seed));
         pulse({3'h0, m});
         for (i = 0; i < 15; i++)
         begin
            n = int'(POLL_ORDER[4 * i +: 4]);
            if (s[n]) call(VEC_BASE + 16'(n * 8), 1);
         end
      end
      wr(OFF_PRIO0, 8'h20);
      wr(OFF_PRIO1, 8'h01);
      rd(OFF_PRIO0, 8'h20);
      pulse(9'h001);
      call(16'h000B, 0);
      pulse(9'h008);
      call(16'h002B, 0);
      pulse(9'h006);
      quiet();
      ret();
      call(16'h003B, 0);
      ret();
      quiet();
      ret();
      call(16'h001B, 1);
      wr(OFF_PRIO0, 8'h00);
      wr(OFF_PRIO1, 8'h00);
      wr(OFF_CAPTION, 8'h05);
      caption_mode <= 1'b1;
      line_number <= 5'h04;
      pulse(9'h040);
      quiet();
      line_number <= 5'h05;
      pulse(9'h040);
      call(16'h0023, 1);
      for (i = 0; i < 5; i++)
      begin
         wr(OFF_DISP_CFG, (i < 3) ? 8'h01 : 8'h00);
         line_active <= (i == 0);
         pulse((i == 1 || i == 3) ? 9'h100 : 9'h080);
         if (i == 0 || i == 3) call(16'h0033, 1); else quiet();
      end
      wr(OFF_TIMER_CTL, 8'h05);
      wr(OFF_EDGE_CFG, 8'h79);
      for (k = 0; k < 6; k++)
      begin
         n = (k < 2) ? 2 * k : k + 9;
         pins[k] <= 1'b0;
         if (k != 2 && k != 5) call(VEC_BASE + 16'(n * 8), 1); else quiet();
         pins[k] <= 1'b1;
         if (k != 0 && k != 3) call(VEC_BASE + 16'(n * 8), 1); else quiet();
      end
      wr(OFF_POWER_CTL, 8'h01);
      check("idle_mode", 32'(idle_mode), 32'h1);
      pulse(9'h001);
      call(16'h000B, 1);
      rd(OFF_POWER_CTL, 8'h00);
      wr(OFF_EDGE_CFG, 8'h00);
      wr(OFF_TIMER_CTL, 8'h00);
      line_active <= 1'b0;
      for (k = 0; k < 2; k++)
      begin
         if (k == 1) wr(OFF_EN0, 8'h00);
         if (k == 1) wr(OFF_EN1, 8'h00);
         wr(OFF_POWER_CTL, 8'h02);
         repeat (3) @(posedge clk);
         check("power_down", {31'h0, power_down}, 32'h1);
         if (k == 0) pins[3] <= 1'b0; else comp <= 1'b1;
         for (n = 0; n < 50 && power_down !== 1'b0; n++) @(posedge clk);
         check("power_down", {31'h0, power_down}, 32'h0);
         if (k == 0) call(16'h0063, 0);
         pins[3] <= 1'b1;
         comp <= 1'b0;
         if (k == 0) ret();
         rd(OFF_POWER_CTL, 8'h00);
      end
      reset <= 1'b1;
      repeat (3) @(posedge clk);
      reset <= 1'b0;
      @(posedge clk);
      rd(OFF_CAPTION, 8'h00);
      quiet();
      check("call count", 32'(ncall), 32'(nexp));
      results();
   end
endmodule
`default_nettype wire
